// ==== rtl/rps_defines.svh ====
//
// Contract
// - a port set to forwarding passes on every packet it receives.
// - a port set to blocking discards every packet it receives.
// - the primary card coordinates protection switching for the whole ring.
// - up to 1024 service vlans may be marked protected.
// - a working path fault moves all protected vlans to the protection path.
// - forced mode treats every vlan as protected, whatever its stored attribute.
// - hold-off disabled, the default, switches immediately on a fault.
// - a selected hold-off of 50 ms to 5 s delays switching by that time.
// - a range protect skips every vlan already in use.
// - crc errors trigger switching only while crc switching is enabled.
// - crc threshold is 1e-2, 1e-3 or 1e-4, default 1e-2.
// - crc alarm rises only after soak count exceedances; soak 3 to 10, default 10.
// - crc error rate is sampled once per poll interval, default 60 seconds.
// - crc switching needs the rate above threshold for soak consecutive polls.
// - alarm suppress clears and withholds the port crc alarm and its switching.
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define RPS_CLK_PERIOD_NS 50
`define RPS_MS_TIME_NS 1000000
`define RPS_MS_CYCLES (`RPS_MS_TIME_NS / `RPS_CLK_PERIOD_NS)
`define RPS_SEC_TIME_MS 1000
`define RPS_HOLD_50_MS 16'd50
`define RPS_HOLD_100_MS 16'd100
`define RPS_HOLD_200_MS 16'd200
`define RPS_HOLD_500_MS 16'd500
`define RPS_HOLD_1S_MS 16'd1000
`define RPS_HOLD_2S_MS 16'd2000
`define RPS_HOLD_5S_MS 16'd5000
`define RPS_MAX_PROTECTED 11'd1024

// -----------------------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------------------
`define RPS_OFF_CTRL 8'h00
`define RPS_OFF_POLL 8'h04
`define RPS_OFF_STATUS 8'h08
`define RPS_OFF_IRQ_STAT 8'h0C
`define RPS_OFF_IRQ_MASK 8'h10
`define RPS_OFF_VLAN_CFG 8'h14
`define RPS_OFF_RANGE 8'h18

// -----------------------------------------------------------------------------
// fields and reset values
// -----------------------------------------------------------------------------
`define RPS_CTRL_MASTER 0
`define RPS_CTRL_MODE_LSB 1
`define RPS_CTRL_HOLD_LSB 3
`define RPS_CTRL_CRC_EN 6
`define RPS_CTRL_THR_LSB 8
`define RPS_CTRL_SOAK_LSB 12
`define RPS_CTRL_BLOCK_LSB 16
`define RPS_CTRL_SUPP_LSB 20
`define RPS_CTRL_RESET 32'h0000A000
`define RPS_POLL_RESET 16'h003C
`define RPS_SOAK_MIN 4'h3
`define RPS_SOAK_MAX 4'hA
`define RPS_VCFG_PROT 12
`define RPS_VCFG_USED 13
`define RPS_RANGE_HI_LSB 16
`define RPS_RANGE_START 31
`define RPS_IRQ_SWITCH 0
`define RPS_IRQ_CANCEL 1
`define RPS_IRQ_RANGE 2
`define RPS_IRQ_ALARM_LSB 3

`endif

// ==== rtl/rps_pkg.sv ====
package rps_pkg;

  typedef enum logic [1:0] {
    RPS_MODE_ENABLED = 2'h0,
    RPS_MODE_DISABLED = 2'h1,
    RPS_MODE_FORCED = 2'h2
  } rps_mode_t;

  typedef enum logic [1:0] {
    RPS_THR_E2 = 2'h0,
    RPS_THR_E3 = 2'h1,
    RPS_THR_E4 = 2'h2
  } rps_thr_t;

  typedef enum {RPS_IDLE, RPS_HOLD, RPS_SWITCHED} rps_state_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [11:0] vid;
    logic [7:0] data;
  } rps_rx_t;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic to_protect;
    logic [11:0] vid;
    logic [7:0] data;
  } rps_tx_t;

endpackage : rps_pkg

// ==== rtl/rps_crc_mon.sv ====
`timescale 1ns/1ps
`include "rps_defines.svh"

module rps_crc_mon (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sec_tick,
  input wire logic [15:0] poll_secs,
  input wire rps_pkg::rps_thr_t thr_sel,
  input wire logic [3:0] soak,
  input wire logic suppress,
  input wire logic frame_seen,
  input wire logic frame_crc_err,
  output logic alarm,
  output logic alarm_rise
);
  import rps_pkg::*;

  logic [31:0] frame_cnt;
  logic [31:0] err_cnt;
  logic [15:0] sec_cnt;
  logic [3:0] soak_cnt;
  logic [15:0] mult;
  logic [47:0] err_scaled;
  logic [3:0] soak_lim;
  logic poll_end;
  logic exceed;

  always_comb begin
    case (thr_sel)
      RPS_THR_E3: mult = 16'h03E8;
      RPS_THR_E4: mult = 16'h2710;
      default: mult = 16'h0064;
    endcase
    err_scaled = {16'h0000, err_cnt} * {32'h0000_0000, mult};
    exceed = err_scaled > {16'h0000, frame_cnt};
    poll_end = sec_tick && (sec_cnt + 16'h0001 >= poll_secs);
    if (soak < `RPS_SOAK_MIN) soak_lim = `RPS_SOAK_MIN;
    else if (soak > `RPS_SOAK_MAX) soak_lim = `RPS_SOAK_MAX;
    else soak_lim = soak;
  end

  // ---------------------------------------------------------------------------
  // poll window counters
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || poll_end) begin
      frame_cnt <= 32'h0000_0000;
      err_cnt <= 32'h0000_0000;
    end else begin
      if (frame_seen) frame_cnt <= frame_cnt + 32'h0000_0001;
      if (frame_seen && frame_crc_err) err_cnt <= err_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || poll_end) sec_cnt <= 16'h0000;
    else if (sec_tick) sec_cnt <= sec_cnt + 16'h0001;
  end

  // ---------------------------------------------------------------------------
  // soak and alarm
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset || suppress) begin
      soak_cnt <= 4'h0;
      alarm <= 1'b0;
      alarm_rise <= 1'b0;
    end else begin
      alarm_rise <= 1'b0;
      if (poll_end) begin
        if (!exceed) begin
          soak_cnt <= 4'h0;
          alarm <= 1'b0;
        end else if (soak_cnt + 4'h1 >= soak_lim) begin
          soak_cnt <= soak_lim;
          alarm <= 1'b1;
          alarm_rise <= !alarm;
        end else begin
          soak_cnt <= soak_cnt + 4'h1;
        end
      end
    end
  end

endmodule : rps_crc_mon

// ==== rtl/rps_ring_switch.sv ====
`timescale 1ns/1ps
`include "rps_defines.svh"

module rps_ring_switch #(
  parameter int NUM_PORTS = 2,
  parameter int VLAN_N = 4096,
  parameter int MS_CYCLES = `RPS_MS_CYCLES,
  parameter int SEC_MS = `RPS_SEC_TIME_MS
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire rps_pkg::rps_rx_t [NUM_PORTS-1:0] rx_pkt,
  input wire logic [NUM_PORTS-1:0] rx_frame_seen,
  input wire logic [NUM_PORTS-1:0] rx_crc_err,
  output rps_pkg::rps_tx_t [NUM_PORTS-1:0] tx_pkt,
  input wire logic working_fault,
  input wire logic ring_cmd_in,
  output logic ring_cmd_out,
  output logic protect_active,
  output logic [NUM_PORTS-1:0] crc_alarm,
  output logic irq
);
  import rps_pkg::*;

  localparam int IRQ_W = `RPS_IRQ_ALARM_LSB + NUM_PORTS;

  logic [31:0] ctrl;
  logic [15:0] poll_secs;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [11:0] cfg_vid;
  logic [VLAN_N-1:0] prot_map;
  logic [VLAN_N-1:0] used_map;
  logic [10:0] prot_count;
  logic range_busy;
  logic [11:0] range_cur;
  logic [11:0] range_hi;
  logic range_done;
  logic [31:0] ms_div;
  logic [15:0] sec_div;
  logic ms_tick;
  logic sec_tick;
  rps_state_t state;
  logic [15:0] hold_cnt;
  logic [15:0] hold_ms;
  logic [NUM_PORTS-1:0] alarm_rise;
  logic crc_trig;
  logic trigger;
  logic ev_switch;
  logic ev_cancel;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] wmask;
  logic [31:0] next_ctrl;
  logic [15:0] next_poll;
  logic [31:0] rd_mux;
  logic map_we;
  logic [11:0] map_vid;
  logic map_val;
  rps_mode_t mode;

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  // request answered one cycle after it arrives: waitrequest drops for one edge
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && avs_waitrequest;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign next_ctrl = (ctrl & ~wmask) | (avs_writedata & wmask);
  assign next_poll = (poll_secs & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
  assign mode = rps_mode_t'(ctrl[`RPS_CTRL_MODE_LSB +: 2]);

  always_ff @(posedge ref_clk) begin
    if (reset) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `RPS_OFF_CTRL: rd_mux = ctrl;
      `RPS_OFF_POLL: rd_mux = {16'h0000, poll_secs};
      `RPS_OFF_STATUS: begin
        rd_mux[0] = protect_active;
        rd_mux[1] = (state == RPS_HOLD);
        rd_mux[2] = range_busy;
        rd_mux[8 +: NUM_PORTS] = crc_alarm;
        rd_mux[26:16] = prot_count;
      end
      `RPS_OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
      `RPS_OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
      `RPS_OFF_VLAN_CFG: begin
        rd_mux[11:0] = cfg_vid;
        rd_mux[`RPS_VCFG_PROT] = prot_map[cfg_vid];
        rd_mux[`RPS_VCFG_USED] = used_map[cfg_vid];
      end
      `RPS_OFF_RANGE: begin
        rd_mux[11:0] = range_cur;
        rd_mux[`RPS_RANGE_HI_LSB +: 12] = range_hi;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) avs_readdata <= 32'h0000_0000;
    else if (rd_ok) avs_readdata <= rd_mux;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl <= `RPS_CTRL_RESET;
      poll_secs <= `RPS_POLL_RESET;
      irq_mask <= '0;
      cfg_vid <= 12'h000;
    end else if (wr_ok) begin
      case (avs_address)
        `RPS_OFF_CTRL: ctrl <= next_ctrl;
        `RPS_OFF_POLL: poll_secs <= next_poll == 16'h0000 ? 16'h0001 : next_poll;
        `RPS_OFF_IRQ_MASK: irq_mask <= avs_writedata[IRQ_W-1:0];
        `RPS_OFF_VLAN_CFG: cfg_vid <= avs_writedata[11:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // interrupts: set wins over write-one-to-clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_ok && avs_address == `RPS_OFF_IRQ_STAT) ?
                   avs_writedata[IRQ_W-1:0] : {IRQ_W{1'b0}}))
                  | {alarm_rise, range_done, ev_cancel, ev_switch};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) irq <= 1'b0;
    else irq <= |(irq_stat & irq_mask);
  end

  // ---------------------------------------------------------------------------
  // vlan database: protect and in-use bits
  // ---------------------------------------------------------------------------
  always_comb begin
    map_we = 1'b0;
    map_vid = range_cur;
    map_val = 1'b1;
    if (range_busy) begin
      // already used vlans are skipped by a range protect
      map_we = !used_map[range_cur] && !prot_map[range_cur];
    end else if (wr_ok && avs_address == `RPS_OFF_VLAN_CFG) begin
      map_we = 1'b1;
      map_vid = avs_writedata[11:0];
      map_val = avs_writedata[`RPS_VCFG_PROT];
    end
    // protected set never grows beyond its limit
    if (map_val && !prot_map[map_vid] && prot_count >= `RPS_MAX_PROTECTED) map_we = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prot_map <= '0;
      prot_count <= 11'h000;
    end else if (map_we && prot_map[map_vid] != map_val) begin
      prot_map[map_vid] <= map_val;
      prot_count <= map_val ? prot_count + 11'h001 : prot_count - 11'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) used_map <= '0;
    else if (!range_busy && wr_ok && avs_address == `RPS_OFF_VLAN_CFG)
      used_map[avs_writedata[11:0]] <= avs_writedata[`RPS_VCFG_USED];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      range_busy <= 1'b0;
      range_cur <= 12'h000;
      range_hi <= 12'h000;
      range_done <= 1'b0;
    end else begin
      range_done <= 1'b0;
      if (range_busy) begin
        range_cur <= range_cur + 12'h001;
        if (range_cur >= range_hi) begin
          range_busy <= 1'b0;
          range_done <= 1'b1;
        end
      end else if (wr_ok && avs_address == `RPS_OFF_RANGE && avs_writedata[`RPS_RANGE_START]) begin
        range_busy <= 1'b1;
        range_cur <= avs_writedata[11:0];
        range_hi <= avs_writedata[`RPS_RANGE_HI_LSB +: 12];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // millisecond and second ticks
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ms_div <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_div == 32'(MS_CYCLES - 1));
      ms_div <= (ms_div == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_div + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sec_div <= 16'h0000;
      sec_tick <= 1'b0;
    end else begin
      sec_tick <= ms_tick && (sec_div == 16'(SEC_MS - 1));
      if (ms_tick) sec_div <= (sec_div == 16'(SEC_MS - 1)) ? 16'h0000 : sec_div + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // crc rate monitor per port
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_crc
    rps_crc_mon u_mon (
      .ref_clk(ref_clk),
      .reset(reset),
      .sec_tick(sec_tick),
      .poll_secs(poll_secs),
      .thr_sel(rps_thr_t'(ctrl[`RPS_CTRL_THR_LSB +: 2])),
      .soak(ctrl[`RPS_CTRL_SOAK_LSB +: 4]),
      .suppress(ctrl[`RPS_CTRL_SUPP_LSB + p]),
      .frame_seen(rx_frame_seen[p]),
      .frame_crc_err(rx_crc_err[p]),
      .alarm(crc_alarm[p]),
      .alarm_rise(alarm_rise[p])
    );
  end

  // suppressed ports already hold their alarm low
  assign crc_trig = ctrl[`RPS_CTRL_CRC_EN] && |crc_alarm;

  // ---------------------------------------------------------------------------
  // switchover state machine
  // ---------------------------------------------------------------------------
  // the primary card decides and commands the ring; others follow its command
  assign trigger = (mode != RPS_MODE_DISABLED) &&
                   (ctrl[`RPS_CTRL_MASTER] ? (working_fault || crc_trig) : ring_cmd_in);

  always_comb begin
    case (ctrl[`RPS_CTRL_HOLD_LSB +: 3])
      3'h1: hold_ms = `RPS_HOLD_50_MS;
      3'h2: hold_ms = `RPS_HOLD_100_MS;
      3'h3: hold_ms = `RPS_HOLD_200_MS;
      3'h4: hold_ms = `RPS_HOLD_500_MS;
      3'h5: hold_ms = `RPS_HOLD_1S_MS;
      3'h6: hold_ms = `RPS_HOLD_2S_MS;
      3'h7: hold_ms = `RPS_HOLD_5S_MS;
      default: hold_ms = 16'h0000;
    endcase
  end

  assign ev_switch = trigger && ((state == RPS_IDLE && hold_ms == 16'h0000) ||
                     (state == RPS_HOLD && ms_tick && hold_cnt <= 16'h0001));
  assign ev_cancel = (state == RPS_HOLD) && !trigger;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= RPS_IDLE;
      hold_cnt <= 16'h0000;
    end else begin
      case (state)
        RPS_IDLE: begin
          hold_cnt <= hold_ms;
          if (trigger) state <= (hold_ms == 16'h0000) ? RPS_SWITCHED : RPS_HOLD;
        end
        RPS_HOLD: begin
          if (!trigger) state <= RPS_IDLE;
          else if (ev_switch) state <= RPS_SWITCHED;
          else if (ms_tick) hold_cnt <= hold_cnt - 16'h0001;
        end
        RPS_SWITCHED: begin
          if (!trigger) state <= RPS_IDLE;
        end
        default: state <= RPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      protect_active <= 1'b0;
      ring_cmd_out <= 1'b0;
    end else begin
      protect_active <= (state == RPS_SWITCHED) || ev_switch;
      ring_cmd_out <= ctrl[`RPS_CTRL_MASTER] && ((state == RPS_SWITCHED) || ev_switch);
    end
  end

  // ---------------------------------------------------------------------------
  // per-port forwarding, blocking and path steering
  // ---------------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic pass_q;
    logic pass_now;
    logic prot_now;
    // decision is taken at the start of a packet and held to its end
    assign pass_now = rx_pkt[p].sop ? !ctrl[`RPS_CTRL_BLOCK_LSB + p] : pass_q;
    assign prot_now = (mode == RPS_MODE_FORCED) || prot_map[rx_pkt[p].vid];

    always_ff @(posedge ref_clk) begin
      if (reset) pass_q <= 1'b0;
      else if (rx_pkt[p].valid && rx_pkt[p].sop) pass_q <= pass_now;
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        tx_pkt[p] <= '0;
      end else begin
        tx_pkt[p].valid <= rx_pkt[p].valid && pass_now;
        tx_pkt[p].sop <= rx_pkt[p].sop;
        tx_pkt[p].eop <= rx_pkt[p].eop;
        tx_pkt[p].vid <= rx_pkt[p].vid;
        tx_pkt[p].data <= rx_pkt[p].data;
        tx_pkt[p].to_protect <= protect_active && prot_now;
      end
    end
  end

endmodule : rps_ring_switch

// ==== dv/rps_ring_node.sv ====
`timescale 1ns/1ps
module rps_ring_node (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic port,
  input wire logic [11:0] vid,
  input wire logic crc_on,
  output rps_pkg::rps_rx_t [1:0] rx_pkt,
  output logic [1:0] rx_frame_seen,
  output logic [1:0] rx_crc_err
);
  import rps_pkg::*;
  logic [1:0] beats = 2'h0;
  logic [11:0] cyc = 12'h000;
  logic [11:0] v = 12'h000;
  logic sel = 1'b0;
  // two-beat packet per go pulse; idle lanes carry a changing pattern
  always_ff @(posedge ref_clk) begin
    cyc <= cyc + 12'h001;
    if (go) begin
      beats <= 2'h2;
      sel <= port;
      v <= vid;
    end else if (beats != 2'h0) begin
      beats <= beats - 2'h1;
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rx_pkt[p] = '{valid: 1'b0, sop: 1'b0, eop: 1'b0, vid: cyc, data: cyc[7:0]};
      if (beats != 2'h0 && sel == p[0]) begin
        rx_pkt[p] = '{valid: 1'b1, sop: beats == 2'h2, eop: beats == 2'h1, vid: v, data: 8'hA5};
      end
    end
  end
  // a frame every other cycle, all errored while crc_on
  assign rx_frame_seen = {2{cyc[0]}};
  assign rx_crc_err = {2{cyc[0] & crc_on}};
endmodule : rps_ring_node

// ==== dv/rps_ring_switch_assertions.sv ====
`timescale 1ns/1ps
module rps_ring_switch_checker #(
  parameter int NUM_PORTS = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire rps_pkg::rps_rx_t [NUM_PORTS-1:0] rx_pkt,
  input wire rps_pkg::rps_tx_t [NUM_PORTS-1:0] tx_pkt,
  input wire logic working_fault,
  input wire logic ring_cmd_in,
  input wire logic ring_cmd_out,
  input wire logic protect_active,
  input wire logic [NUM_PORTS-1:0] crc_alarm
);
  import rps_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer one cycle after request");
  property p_wait_single;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("waitrequest low for more than one cycle");
  property p_tx0_cause;
    tx_pkt[0].valid |-> $past(rx_pkt[0].valid) && tx_pkt[0].vid == $past(rx_pkt[0].vid);
  endproperty
  a_tx0_cause: assert property (p_tx0_cause) else $error("port 0 beat without matching receive");
  property p_tx1_cause;
    tx_pkt[1].valid |-> $past(rx_pkt[1].valid) && tx_pkt[1].sop == $past(rx_pkt[1].sop)
      && tx_pkt[1].data == $past(rx_pkt[1].data);
  endproperty
  a_tx1_cause: assert property (p_tx1_cause) else $error("port 1 beat differs from receive");
  property p_prot_tag;
    tx_pkt[1].valid && tx_pkt[1].to_protect |-> protect_active || $past(protect_active);
  endproperty
  a_prot_tag: assert property (p_prot_tag) else $error("protect path used while not switched");
  property p_cmd_rise;
    $rose(ring_cmd_out) |-> $rose(protect_active);
  endproperty
  a_cmd_rise: assert property (p_cmd_rise) else $error("ring command without own switch");
  property p_cmd_fall;
    $fell(protect_active) |-> !ring_cmd_out;
  endproperty
  a_cmd_fall: assert property (p_cmd_fall) else $error("ring command outlives switch");
  property p_switch_cause;
    $rose(protect_active) |-> $past(working_fault) || $past(ring_cmd_in) || (|crc_alarm);
  endproperty
  a_switch_cause: assert property (p_switch_cause) else $error("switch without trigger");
endmodule : rps_ring_switch_checker

bind rps_ring_switch rps_ring_switch_checker #(.NUM_PORTS(NUM_PORTS)) i_rps_ring_switch_checker (
  .ref_clk(ref_clk), .reset(reset), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .rx_pkt(rx_pkt), .tx_pkt(tx_pkt), .working_fault(working_fault),
  .ring_cmd_in(ring_cmd_in), .ring_cmd_out(ring_cmd_out), .protect_active(protect_active),
  .crc_alarm(crc_alarm));

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`include "rps_defines.svh"
module testbench;
  import rps_pkg::*;
  localparam int MS = 4;
  logic ref_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq;
  logic working_fault = 1'b0, ring_cmd_out, protect_active, go = 1'b0, port = 1'b0, crc_on = 1'b0;
  logic ring_cmd_in = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [11:0] vid = 12'h000;
  logic [1:0] rx_frame_seen, rx_crc_err, crc_alarm;
  rps_rx_t [1:0] rx_pkt;
  rps_tx_t [1:0] tx_pkt;
  int mismatches = 0, checks = 0, n, k;
  int hold_ms [7] = '{50, 100, 200, 500, 1000, 2000, 5000};
  rps_ring_switch #(.NUM_PORTS(2), .MS_CYCLES(MS), .SEC_MS(3)) i_rps_ring_switch (
    .ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pkt(rx_pkt), .rx_frame_seen(rx_frame_seen), .rx_crc_err(rx_crc_err),
    .tx_pkt(tx_pkt), .working_fault(working_fault), .ring_cmd_in(ring_cmd_in), .ring_cmd_out(ring_cmd_out),
    .protect_active(protect_active), .crc_alarm(crc_alarm), .irq(irq));
  rps_ring_node i_rps_ring_node (.ref_clk(ref_clk), .go(go), .port(port), .vid(vid), .crc_on(crc_on),
    .rx_pkt(rx_pkt), .rx_frame_seen(rx_frame_seen), .rx_crc_err(rx_crc_err));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic give_up(input int c, input int lim);
    if (c >= lim) begin
      mismatches++;
      complete_run();
    end
  endtask : give_up
  // avalon access; request held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    give_up(n, 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wait_pa(input logic v, input int lim);
    for (n = 0; n < lim && protect_active !== v; n++) @(posedge ref_clk);
    give_up(n, lim);
    cmp(protect_active, v);
  endtask : wait_pa
  // first beat of a packet, one edge after it was taken
  task automatic send(input logic p, input logic [11:0] v, input logic fwd, input logic prot);
    port <= p;
    vid <= v;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (2) @(posedge ref_clk);
    cmp(tx_pkt[p].valid, fwd);
    if (fwd) cmp({tx_pkt[p].to_protect, tx_pkt[p].vid}, {prot, v});
  endtask : send
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, `RPS_OFF_CTRL, 32'h0);
    cmp(rd, 32'hA << `RPS_CTRL_SOAK_LSB);
    bus(1'b0, `RPS_OFF_POLL, 32'h0);
    cmp(rd, 32'h3C);
    bus(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b1, `RPS_OFF_POLL, 32'h1);
    bus(1'b1, `RPS_OFF_IRQ_MASK, 32'h1F);
    bus(1'b1, `RPS_OFF_VLAN_CFG, 32'h1005);
    bus(1'b1, `RPS_OFF_VLAN_CFG, 32'h200A);
    bus(1'b1, `RPS_OFF_RANGE, 32'h800C0008);
    for (k = 0; k < 50; k++) begin
      bus(1'b0, `RPS_OFF_STATUS, 32'h0);
      if (rd[2] === 1'b0) break;
    end
    give_up(k, 50);
    cmp(rd[26:16], 11'h005);
    cmp(irq, 1'b1);
    bus(1'b1, `RPS_OFF_IRQ_MASK, 32'h0);
    @(posedge ref_clk);
    cmp(irq, 1'b0);
    bus(1'b1, `RPS_OFF_IRQ_STAT, 32'h1F);
    bus(1'b1, `RPS_OFF_IRQ_MASK, 32'h1F);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00013001);
    send(1'b0, 12'h009, 1'b0, 1'b0);
    send(1'b1, 12'h009, 1'b1, 1'b0);
    working_fault <= 1'b1;
    wait_pa(1'b1, 5);
    cmp(ring_cmd_out, 1'b1);
    send(1'b1, 12'h009, 1'b1, 1'b1);
    send(1'b1, 12'h00A, 1'b1, 1'b0);
    send(1'b1, 12'h005, 1'b1, 1'b1);
    cmp(irq, 1'b1);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00013005);
    send(1'b1, 12'h00A, 1'b1, 1'b1);
    working_fault <= 1'b0;
    wait_pa(1'b0, 5);
    for (k = 0; k < 7; k++) begin
      bus(1'b1, `RPS_OFF_CTRL, 32'h00003001 | ((k + 1) << `RPS_CTRL_HOLD_LSB));
      working_fault <= 1'b1;
      wait_pa(1'b1, hold_ms[k] * MS + 8);
      cmp(n >= hold_ms[k] * MS - 4, 1'b1);
      working_fault <= 1'b0;
      wait_pa(1'b0, 5);
    end
    bus(1'b1, `RPS_OFF_IRQ_STAT, 32'h1F);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00003009);
    working_fault <= 1'b1;
    repeat (100) @(posedge ref_clk);
    working_fault <= 1'b0;
    repeat (200) @(posedge ref_clk);
    cmp(protect_active, 1'b0);
    bus(1'b0, `RPS_OFF_IRQ_STAT, 32'h0);
    cmp(rd[1:0], 2'h2);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00003003);
    working_fault <= 1'b1;
    repeat (10) @(posedge ref_clk);
    cmp(protect_active, 1'b0);
    working_fault <= 1'b0;
    bus(1'b1, `RPS_OFF_CTRL, 32'h00003000);
    ring_cmd_in <= 1'b1;
    wait_pa(1'b1, 5);
    cmp(ring_cmd_out, 1'b0);
    ring_cmd_in <= 1'b0;
    wait_pa(1'b0, 5);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00003001);
    crc_on <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cmp(crc_alarm, 2'h0);
    for (k = 0; k < 60 && crc_alarm !== 2'h3; k++) @(posedge ref_clk);
    give_up(k, 60);
    cmp(protect_active, 1'b0);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00003041);
    wait_pa(1'b1, 8);
    bus(1'b1, `RPS_OFF_CTRL, 32'h00303041);
    wait_pa(1'b0, 8);
    cmp(crc_alarm, 2'h0);
    crc_on <= 1'b0;
    complete_run();
  end
endmodule : testbench
